// ===== logic/field_access_bank.sv
// Bank of eight register fields, one of each software access behaviour.
// Assumes a single clock and strobes that are one-cycle pulses on clk_i.
//
// Notes on behaviour
// R1 - Clear-on-read field zeroes after being read.
// R2 - Writes to read-only supply its reset value.
// R3 - Read/write field stores and returns written data.
// R4 - Any write clears a clear-on-write register.
// R5 - Write-one-to-clear: ones clear, zeros keep.
// R6 - Writing read status back clears only those.
// R7 - Write-one-to-set: ones set, zeros keep.
// R8 - Write-only clear field: reads meaningless.
// R9 - Write-only register: reads carry no meaning.
// R10 - Every field takes its reset value.
// R11 - Asserted high-active is 1, low-active 0.
// R12 - Reserved bits read zero, software preserves.
// R13 - Hardware set wins over same-cycle clear.
`timescale 1ns/100ps
`default_nettype none
module field_access_bank
  import field_access_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Software access port
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [FIELD_W-1:0] wdata_i,
  output logic [FIELD_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic unmapped_o,
  output logic ro_write_err_o,
  // Hardware events and status
  input wire logic [FIELD_W-1:0] status_i,
  input wire logic [FIELD_W-1:0] count_event_i,
  input wire logic [FIELD_W-1:0] clr_event_i,
  input wire logic [FIELD_W-1:0] irq_event_i,
  input wire logic [FIELD_W-1:0] wo_event_i,
  // Field values and write strobe toward hardware
  output logic [FIELD_W-1:0] ctrl_o,
  output logic [FIELD_W-1:0] set_bits_o,
  output logic [FIELD_W-1:0] wo_data_o,
  output logic wo_strobe_o,
  output logic [FIELD_W-1:0] pending_o,
  // Interrupt pins
  output logic irq_o,
  output logic irq_n_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  logic hit_ctrl;
  logic hit_stat;
  logic hit_rcnt;
  logic hit_wclr;
  logic hit_irqs;
  logic hit_setb;
  logic hit_wocl;
  logic hit_wdat;
  logic hit_any;

  assign hit_ctrl = sel_hit(sel_i, IDX_CTRL);
  assign hit_stat = sel_hit(sel_i, IDX_STAT);
  assign hit_rcnt = sel_hit(sel_i, IDX_RCNT);
  assign hit_wclr = sel_hit(sel_i, IDX_WCLR);
  assign hit_irqs = sel_hit(sel_i, IDX_IRQS);
  assign hit_setb = sel_hit(sel_i, IDX_SETB);
  assign hit_wocl = sel_hit(sel_i, IDX_WOCL);
  assign hit_wdat = sel_hit(sel_i, IDX_WDAT);
  assign hit_any = hit_ctrl | hit_stat | hit_rcnt | hit_wclr | hit_irqs | hit_setb | hit_wocl
                 | hit_wdat;

  // A write and a read in the same cycle are both honoured; a clear-on-read field then
  // returns its old value, which is the only safe answer.
  logic wr_ctrl;
  logic wr_stat;
  logic wr_rcnt;
  logic wr_wclr;
  logic wr_irqs;
  logic wr_setb;
  logic wr_wocl;
  logic wr_wdat;
  logic rd_rcnt;

  assign wr_ctrl = wr_i & hit_ctrl;
  assign wr_stat = wr_i & hit_stat;
  assign wr_rcnt = wr_i & hit_rcnt;
  assign wr_wclr = wr_i & hit_wclr;
  assign wr_irqs = wr_i & hit_irqs;
  assign wr_setb = wr_i & hit_setb;
  assign wr_wocl = wr_i & hit_wocl;
  assign wr_wdat = wr_i & hit_wdat;
  assign rd_rcnt = rd_i & hit_rcnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Fields

  logic [FIELD_W-1:0] rd_ctrl;
  logic [FIELD_W-1:0] rd_stat;
  logic [FIELD_W-1:0] rd_rcntv;
  logic [FIELD_W-1:0] rd_wclr;
  logic [FIELD_W-1:0] rd_irqs;
  logic [FIELD_W-1:0] rd_setb;
  logic [FIELD_W-1:0] rd_wocl;
  logic [FIELD_W-1:0] rd_wdat;
  logic [FIELD_W-1:0] val_ctrl;
  logic [FIELD_W-1:0] val_irqs;
  logic [FIELD_W-1:0] val_setb;
  logic [FIELD_W-1:0] val_wocl;
  logic [FIELD_W-1:0] val_wdat;

  field_cell #(
    .ACCESS(ACC_RW),
    .RST_VAL(RST_CTRL),
    .MASK(MSK_CTRL)
  ) u_ctrl (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_ctrl),
    .rd_i(1'b0),
    .wdata_i(wdata_i),
    .rdata_o(rd_ctrl),
    .hw_set_i(ZERO_DATA),
    .hw_val_i(ZERO_DATA),
    .value_o(val_ctrl)
  );

  field_cell #(
    .ACCESS(ACC_RO),
    .RST_VAL(RST_STAT),
    .MASK(MSK_STAT)
  ) u_stat (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_stat),
    .rd_i(1'b0),
    .wdata_i(wdata_i),
    .rdata_o(rd_stat),
    .hw_set_i(ZERO_DATA),
    .hw_val_i(status_i),
    .value_o()
  );

  field_cell #(
    .ACCESS(ACC_RC),
    .RST_VAL(RST_RCNT),
    .MASK(MSK_RCNT)
  ) u_rcnt (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_rcnt),
    .rd_i(rd_rcnt),
    .wdata_i(wdata_i),
    .rdata_o(rd_rcntv),
    .hw_set_i(count_event_i),
    .hw_val_i(ZERO_DATA),
    .value_o()
  );

  field_cell #(
    .ACCESS(ACC_RWC),
    .RST_VAL(RST_WCLR),
    .MASK(MSK_WCLR)
  ) u_wclr (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_wclr),
    .rd_i(1'b0),
    .wdata_i(wdata_i),
    .rdata_o(rd_wclr),
    .hw_set_i(clr_event_i),
    .hw_val_i(ZERO_DATA),
    .value_o()
  );

  field_cell #(
    .ACCESS(ACC_RW1C),
    .RST_VAL(RST_IRQS),
    .MASK(MSK_IRQS)
  ) u_irqs (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_irqs),
    .rd_i(1'b0),
    .wdata_i(wdata_i),
    .rdata_o(rd_irqs),
    .hw_set_i(irq_event_i),
    .hw_val_i(ZERO_DATA),
    .value_o(val_irqs)
  );

  field_cell #(
    .ACCESS(ACC_RW1S),
    .RST_VAL(RST_SETB),
    .MASK(MSK_SETB)
  ) u_setb (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_setb),
    .rd_i(1'b0),
    .wdata_i(wdata_i),
    .rdata_o(rd_setb),
    .hw_set_i(ZERO_DATA),
    .hw_val_i(ZERO_DATA),
    .value_o(val_setb)
  );

  field_cell #(
    .ACCESS(ACC_W1C),
    .RST_VAL(RST_WOCL),
    .MASK(MSK_WOCL)
  ) u_wocl (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_wocl),
    .rd_i(1'b0),
    .wdata_i(wdata_i),
    .rdata_o(rd_wocl),
    .hw_set_i(wo_event_i),
    .hw_val_i(ZERO_DATA),
    .value_o(val_wocl)
  );

  field_cell #(
    .ACCESS(ACC_WO),
    .RST_VAL(RST_WDAT),
    .MASK(MSK_WDAT)
  ) u_wdat (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_wdat),
    .rd_i(1'b0),
    .wdata_i(wdata_i),
    .rdata_o(rd_wdat),
    .hw_set_i(ZERO_DATA),
    .hw_val_i(ZERO_DATA),
    .value_o(val_wdat)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [FIELD_W-1:0] read_mux;
  logic [FIELD_W-1:0] next_rdata;

  assign read_mux = ({FIELD_W{hit_ctrl}} & rd_ctrl)
                  | ({FIELD_W{hit_stat}} & rd_stat)
                  | ({FIELD_W{hit_rcnt}} & rd_rcntv)
                  | ({FIELD_W{hit_wclr}} & rd_wclr)
                  | ({FIELD_W{hit_irqs}} & rd_irqs)
                  | ({FIELD_W{hit_setb}} & rd_setb)
                  | ({FIELD_W{hit_wocl}} & rd_wocl)
                  | ({FIELD_W{hit_wdat}} & rd_wdat);

  // R1 return before clear. The capture uses the value before the read's own clear lands.
  assign next_rdata = rd_i ? read_mux : rdata_o;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= ZERO_DATA;
      rvalid_o <= 1'b0;
      unmapped_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      rvalid_o <= rd_i;
      unmapped_o <= (rd_i | wr_i) & ~hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Misuse report

  // R2 read-only write check. Data whose implemented bits differ from the reset value is flagged, never stored.
  logic next_ro_err;

  assign next_ro_err = wr_stat & ((wdata_i & MSK_STAT) != (RST_STAT & MSK_STAT));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ro_write_err_o <= 1'b0;
    end else begin
      ro_write_err_o <= next_ro_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs toward hardware

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wo_strobe_o <= 1'b0;
    end else begin
      wo_strobe_o <= wr_wdat;
    end
  end

  assign ctrl_o = val_ctrl;
  assign set_bits_o = val_setb;
  assign wo_data_o = val_wdat;
  assign pending_o = val_wocl;

  // R6 only reported bits clear. The cell clears written ones only, so later events stay.
  logic irq_level;

  assign irq_level = |(val_irqs & val_ctrl) | (|val_wocl);

  signal_drive #(
    .ACTIVE_LOW(1'b0)
  ) u_irq_hi (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .assert_i(irq_level),
    .pin_o(irq_o)
  );

  // R11 low-active copy.
  signal_drive #(
    .ACTIVE_LOW(1'b1)
  ) u_irq_lo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .assert_i(irq_level),
    .pin_o(irq_n_o)
  );

endmodule : field_access_bank
`default_nettype wire

// ===== logic/field_access_pkg.sv
// Shared constants and types for the register field access bank.
// Assumes every user of it imports the whole package.
package field_access_pkg;

  // Software access behaviour of one field.
  typedef enum logic [3:0] {
    ACC_RW   = 4'h0,
    ACC_RO   = 4'h1,
    ACC_RC   = 4'h2,
    ACC_RWC  = 4'h3,
    ACC_RW1C = 4'h4,
    ACC_RW1S = 4'h5,
    ACC_W1C  = 4'h6,
    ACC_WO   = 4'h7
  } access_t;

  localparam int FIELD_W = 8;
  localparam int SEL_W = 4;

  // Field indices on the access port.
  localparam logic [SEL_W-1:0] IDX_CTRL = 4'h0;
  localparam logic [SEL_W-1:0] IDX_STAT = 4'h1;
  localparam logic [SEL_W-1:0] IDX_RCNT = 4'h2;
  localparam logic [SEL_W-1:0] IDX_WCLR = 4'h3;
  localparam logic [SEL_W-1:0] IDX_IRQS = 4'h4;
  localparam logic [SEL_W-1:0] IDX_SETB = 4'h5;
  localparam logic [SEL_W-1:0] IDX_WOCL = 4'h6;
  localparam logic [SEL_W-1:0] IDX_WDAT = 4'h7;

  // Values after reset.
  localparam logic [FIELD_W-1:0] RST_CTRL = 8'h00;
  localparam logic [FIELD_W-1:0] RST_STAT = 8'h00;
  localparam logic [FIELD_W-1:0] RST_RCNT = 8'h00;
  localparam logic [FIELD_W-1:0] RST_WCLR = 8'h00;
  localparam logic [FIELD_W-1:0] RST_IRQS = 8'h00;
  localparam logic [FIELD_W-1:0] RST_SETB = 8'h01;
  localparam logic [FIELD_W-1:0] RST_WOCL = 8'h00;
  localparam logic [FIELD_W-1:0] RST_WDAT = 8'h00;

  // Implemented bits; the rest are reserved and read as zero.
  localparam logic [FIELD_W-1:0] MSK_CTRL = 8'hff;
  localparam logic [FIELD_W-1:0] MSK_STAT = 8'h7f;
  localparam logic [FIELD_W-1:0] MSK_RCNT = 8'hff;
  localparam logic [FIELD_W-1:0] MSK_WCLR = 8'h0f;
  localparam logic [FIELD_W-1:0] MSK_IRQS = 8'hff;
  localparam logic [FIELD_W-1:0] MSK_SETB = 8'hff;
  localparam logic [FIELD_W-1:0] MSK_WOCL = 8'hff;
  localparam logic [FIELD_W-1:0] MSK_WDAT = 8'hff;

  localparam logic [FIELD_W-1:0] ZERO_DATA = 8'h00;

  // True when the access port addresses the given field.
  function automatic logic sel_hit(input logic [SEL_W-1:0] sel, input logic [SEL_W-1:0] idx);
    sel_hit = (sel == idx);
  endfunction : sel_hit

endpackage : field_access_pkg

// ===== logic/field_cell.sv
// One register field with a selectable software access behaviour.
// Assumes write and read strobes are one-cycle pulses from the bank.
`timescale 1ns/100ps
`default_nettype none
module field_cell
  import field_access_pkg::*;
#(
  parameter access_t ACCESS = ACC_RW,
  parameter logic [FIELD_W-1:0] RST_VAL = 8'h00,
  parameter logic [FIELD_W-1:0] MASK = 8'hff
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Software side
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [FIELD_W-1:0] wdata_i,
  output logic [FIELD_W-1:0] rdata_o,
  // Hardware side
  input wire logic [FIELD_W-1:0] hw_set_i,
  input wire logic [FIELD_W-1:0] hw_val_i,
  output logic [FIELD_W-1:0] value_o
);

  logic [FIELD_W-1:0] value;
  logic [FIELD_W-1:0] next_value;
  logic [FIELD_W-1:0] wr_bits;
  logic [FIELD_W-1:0] kept;
  logic [FIELD_W-1:0] raw_next;
  logic hidden;

  assign wr_bits = wr_i ? wdata_i : ZERO_DATA;

  always_comb begin
    kept = value;
    case (ACCESS)
      // R3 plain store.
      ACC_RW: kept = wr_i ? wdata_i : value;
      // R9 write only store.
      ACC_WO: kept = wr_i ? wdata_i : value;
      // Status mirror; software writes have no effect.
      ACC_RO: kept = hw_val_i;
      // R1 clear after read.
      ACC_RC: kept = rd_i ? ZERO_DATA : value;
      // R4 any write clears.
      ACC_RWC: kept = wr_i ? ZERO_DATA : value;
      // R5 R8 R6 clear written ones.
      ACC_RW1C: kept = value & ~wr_bits;
      ACC_W1C: kept = value & ~wr_bits;
      // R7 written ones set.
      ACC_RW1S: kept = value | wr_bits;
      default: kept = value;
    endcase
  end

  // R13 set beats clear. The set is merged after the clear so a same-cycle event survives.
  assign raw_next = (ACCESS == ACC_RO) ? kept : (kept | hw_set_i);
  // R12 reserved bits zero.
  assign next_value = raw_next & MASK;

  // R10 reset value.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      value <= RST_VAL & MASK;
    end else begin
      value <= next_value;
    end
  end

  // R8 R9 reads carry nothing. Zero is returned so no stored state leaks out.
  assign hidden = (ACCESS == ACC_W1C) || (ACCESS == ACC_WO);
  assign rdata_o = hidden ? ZERO_DATA : value;
  assign value_o = value;

endmodule : field_cell
`default_nettype wire

// ===== logic/signal_drive.sv
// Drives one output pin at the chosen active polarity from a logical assert.
// Assumes the assert level is synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module signal_drive #(
  parameter bit ACTIVE_LOW = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Logical level and pin
  input wire logic assert_i,
  output logic pin_o
);

  logic next_pin;

  // R11 polarity of assert. Low-active pins idle high, so reset deasserts them.
  assign next_pin = ACTIVE_LOW ? ~assert_i : assert_i;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o <= ACTIVE_LOW;
    end else begin
      pin_o <= next_pin;
    end
  end

endmodule : signal_drive
`default_nettype wire

// ===== bench/field_access_assertions.sv
// Port-level checks for the field access bank.
// Assumes one clock domain; bound to every bank instance below.
`timescale 1ns/100ps
`default_nettype none
module field_access_assertions
  import field_access_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Software port
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [FIELD_W-1:0] wdata_i,
  input wire logic [FIELD_W-1:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic unmapped_o,
  input wire logic ro_write_err_o,
  // Hardware side
  input wire logic [FIELD_W-1:0] count_event_i,
  input wire logic [FIELD_W-1:0] clr_event_i,
  input wire logic [FIELD_W-1:0] wo_event_i,
  input wire logic [FIELD_W-1:0] ctrl_o,
  input wire logic [FIELD_W-1:0] set_bits_o,
  input wire logic [FIELD_W-1:0] wo_data_o,
  input wire logic wo_strobe_o,
  input wire logic [FIELD_W-1:0] pending_o,
  input wire logic irq_o,
  input wire logic irq_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence rc_twice;
    rd_i && sel_i == IDX_RCNT ##1 rd_i && sel_i == IDX_RCNT;
  endsequence
  sequence wc_then_rd;
    wr_i && sel_i == IDX_WCLR && clr_event_i == ZERO_DATA ##1 rd_i && sel_i == IDX_WCLR;
  endsequence

  AST_RVALID: assert property (rd_i |=> rvalid_o)
    else $error("no read valid after read");
  AST_RC_CLEAR: assert property (rc_twice |=> rdata_o == $past(count_event_i, 2))
    else $error("read clear field kept old bits");
  AST_WC_CLEAR: assert property (wc_then_rd |=> rdata_o == ZERO_DATA)
    else $error("write clear field not zero");
  AST_RO_FLAG: assert property (wr_i && sel_i == IDX_STAT |=>
    ro_write_err_o == (($past(wdata_i) & MSK_STAT) != RST_STAT))
    else $error("read only write flag wrong");
  AST_CTRL_WR: assert property (wr_i && sel_i == IDX_CTRL |=> ctrl_o == $past(wdata_i))
    else $error("control field not stored");
  AST_SET_ONES: assert property (wr_i && sel_i == IDX_SETB |=>
    set_bits_o == ($past(set_bits_o) | $past(wdata_i)))
    else $error("set field wrong");
  AST_W1C_PEND: assert property (wr_i && sel_i == IDX_WOCL |=>
    pending_o == ($past(pending_o) & ~$past(wdata_i) | $past(wo_event_i)))
    else $error("pending clear wrong");
  AST_WO_STROBE: assert property (wr_i && sel_i == IDX_WDAT |=>
    wo_strobe_o && wo_data_o == $past(wdata_i))
    else $error("write only data wrong");
  AST_UNMAP: assert property (rd_i && sel_i[SEL_W-1] |=> unmapped_o && rdata_o == ZERO_DATA)
    else $error("unmapped read wrong");
  AST_IRQ_POL: assert property (irq_n_o == !irq_o)
    else $error("interrupt pins not inverse");
endmodule : field_access_assertions

bind field_access_bank field_access_assertions field_access_assertions_i (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .sel_i(sel_i), .wr_i(wr_i), .rd_i(rd_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .unmapped_o(unmapped_o),
  .ro_write_err_o(ro_write_err_o), .count_event_i(count_event_i),
  .clr_event_i(clr_event_i), .wo_event_i(wo_event_i), .ctrl_o(ctrl_o),
  .set_bits_o(set_bits_o), .wo_data_o(wo_data_o), .wo_strobe_o(wo_strobe_o),
  .pending_o(pending_o), .irq_o(irq_o), .irq_n_o(irq_n_o));
`default_nettype wire

// ===== bench/field_access_bank_tb.sv
// Directed bench for the field access bank, one task per scenario.
// Assumes the checker is bound in by its own file.
`timescale 1ns/100ps
`default_nettype none
module field_access_bank_tb
  import field_access_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [SEL_W-1:0] sel = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] status = 8'h00;
  logic [7:0] cnt_ev = 8'h00;
  logic [7:0] clr_ev = 8'h00;
  logic [7:0] irq_ev = 8'h00;
  logic [7:0] wo_ev = 8'h00;
  logic [7:0] rdata, ctrl, set_bits, wo_data, pending;
  logic rvalid, unmapped, ro_err, wo_strobe, irq, irq_n;
  logic [7:0] rv [6] = '{RST_CTRL, RST_STAT, RST_RCNT, RST_WCLR, RST_IRQS, RST_SETB};
  int fail_count = 0;
  int total_checks = 0;

  field_access_bank field_access_bank_i (
    .clk_i(clk), .arst_n_i(arst_n), .sel_i(sel), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .unmapped_o(unmapped),
    .ro_write_err_o(ro_err), .status_i(status), .count_event_i(cnt_ev),
    .clr_event_i(clr_ev), .irq_event_i(irq_ev), .wo_event_i(wo_ev), .ctrl_o(ctrl),
    .set_bits_o(set_bits), .wo_data_o(wo_data), .wo_strobe_o(wo_strobe),
    .pending_o(pending), .irq_o(irq), .irq_n_o(irq_n));

  initial begin
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  // Accesses are driven on a rising edge; done releases the strobes
  // and waits past the next edge so results are settled.
  task automatic acc(input logic [3:0] s, input logic w, input logic r, input logic [7:0] d);
    @(posedge clk);
    sel <= s;
    wr <= w;
    rd <= r;
    wdata <= d;
  endtask : acc

  task automatic done();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask : done

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic t_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk("ctrl", RST_CTRL, ctrl);
    chk("set_bits", RST_SETB, set_bits);
    chk("pending", RST_WOCL, pending);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    for (int i = 0; i < 6; i++) begin
      acc(i[3:0], 1'b0, 1'b1, 8'h00);
      done();
      chk("reset read", rv[i], rdata);
    end
  endtask : t_reset

  task automatic t_rw();
    acc(IDX_CTRL, 1'b1, 1'b0, 8'h5a);
    done();
    chk("ctrl", 8'h5a, ctrl);
    acc(IDX_CTRL, 1'b1, 1'b1, 8'hff);
    done();
    chk("rw old read", 8'h5a, rdata);
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("ctrl", 8'hff, ctrl);
  endtask : t_rw

  task automatic t_ro();
    acc(IDX_STAT, 1'b1, 1'b0, 8'h00);
    status <= 8'hff;
    done();
    chk("ro flag", 8'h00, {7'h00, ro_err});
    acc(IDX_STAT, 1'b1, 1'b1, 8'h01);
    status <= 8'h00;
    done();
    chk("ro flag", 8'h01, {7'h00, ro_err});
    chk("ro read", 8'h7f, rdata);
  endtask : t_ro

  task automatic t_rc();
    acc(IDX_RCNT, 1'b0, 1'b1, 8'h00);
    cnt_ev <= 8'h3c;
    acc(IDX_RCNT, 1'b0, 1'b1, 8'h00);
    cnt_ev <= 8'h00;
    done();
    chk("rc set", 8'h3c, rdata);
    acc(IDX_RCNT, 1'b0, 1'b1, 8'h00);
    done();
    chk("rc cleared", 8'h00, rdata);
  endtask : t_rc

  task automatic t_rwc();
    acc(IDX_WCLR, 1'b0, 1'b1, 8'h00);
    clr_ev <= 8'hff;
    acc(IDX_WCLR, 1'b0, 1'b1, 8'h00);
    clr_ev <= 8'h00;
    done();
    chk("wc masked", 8'h0f, rdata);
    acc(IDX_WCLR, 1'b1, 1'b0, 8'ha5);
    acc(IDX_WCLR, 1'b0, 1'b1, 8'h00);
    done();
    chk("wc cleared", 8'h00, rdata);
  endtask : t_rwc

  task automatic t_w1c();
    acc(IDX_IRQS, 1'b0, 1'b1, 8'h00);
    irq_ev <= 8'h0f;
    acc(IDX_IRQS, 1'b0, 1'b1, 8'h00);
    irq_ev <= 8'h00;
    done();
    chk("w1c status", 8'h0f, rdata);
    chk("irq", 8'h01, {7'h00, irq});
    chk("irq_n", 8'h00, {7'h00, irq_n});
    acc(IDX_IRQS, 1'b1, 1'b1, 8'h0f);
    irq_ev <= 8'h30;
    acc(IDX_IRQS, 1'b0, 1'b1, 8'h00);
    irq_ev <= 8'h00;
    done();
    chk("w1c new event", 8'h30, rdata);
    acc(IDX_IRQS, 1'b1, 1'b0, 8'h10);
    acc(IDX_IRQS, 1'b0, 1'b1, 8'h00);
    done();
    chk("w1c keep", 8'h20, rdata);
    acc(IDX_IRQS, 1'b1, 1'b0, 8'h20);
    done();
    done();
    chk("irq", 8'h00, {7'h00, irq});
  endtask : t_w1c

  task automatic t_w1s();
    acc(IDX_SETB, 1'b1, 1'b0, 8'h80);
    acc(IDX_SETB, 1'b1, 1'b0, 8'h00);
    acc(IDX_SETB, 1'b0, 1'b1, 8'h00);
    done();
    chk("w1s read", 8'h81, rdata);
    chk("w1s out", 8'h81, set_bits);
  endtask : t_w1s

  task automatic t_wocl();
    acc(IDX_WOCL, 1'b0, 1'b1, 8'h00);
    wo_ev <= 8'hc3;
    done();
    chk("w1c only read", 8'h00, rdata);
    chk("pending", 8'hc3, pending);
    acc(IDX_WOCL, 1'b1, 1'b0, 8'h41);
    wo_ev <= 8'h01;
    done();
    chk("pending", 8'h83, pending);
    acc(IDX_WOCL, 1'b1, 1'b0, 8'h83);
    wo_ev <= 8'h00;
    done();
    chk("pending", 8'h00, pending);
  endtask : t_wocl

  task automatic t_wo();
    acc(IDX_WDAT, 1'b1, 1'b0, 8'h9e);
    done();
    chk("wo data", 8'h9e, wo_data);
    chk("wo strobe", 8'h01, {7'h00, wo_strobe});
    acc(IDX_WDAT, 1'b0, 1'b1, 8'h00);
    done();
    chk("wo read", 8'h00, rdata);
    chk("wo strobe", 8'h00, {7'h00, wo_strobe});
  endtask : t_wo

  task automatic t_unmap();
    for (int s = 8; s < 16; s++) begin
      acc(s[3:0], 1'b1, 1'b1, 8'hff);
      done();
      chk("unmapped", 8'h01, {7'h00, unmapped});
      chk("unmapped read", 8'h00, rdata);
    end
  endtask : t_unmap

  initial begin
    t_reset();
    t_rw();
    t_ro();
    t_rc();
    t_rwc();
    t_w1c();
    t_w1s();
    t_wocl();
    t_wo();
    t_unmap();
    t_reset();
    stop_test();
  end

  // The run needs about 90 cycles; this cuts a hang well after that.
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule : field_access_bank_tb
`default_nettype wire
